// [core/ftfc_buf.sv]
`timescale 1ns/1ps
module ftfc_buf
#(
   parameter int WIDTH = 5,
   parameter int DEPTH = 8
)
(
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("ftfc_buf depth must be a power of two");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             in_ready_reg;
   logic             push;
   logic             pop;

   // ready registered so the host's write ready leaves a flip-flop
   assign in_ready  = in_ready_reg;
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge core_clk)
   begin
      if (push)
         mem_reg[wr_ptr_reg] <= in_data;
   end

   always_comb
   begin
      count_next = count_reg;
      if (push && !pop)
         count_next = count_reg + 1'b1;
      else if (pop && !push)
         count_next = count_reg - 1'b1;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         wr_ptr_reg   <= '0;
         rd_ptr_reg   <= '0;
         count_reg    <= '0;
         in_ready_reg <= 1'b1;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         count_reg    <= count_next;
         in_ready_reg <= (count_next != (AW+1)'(DEPTH));
      end
   end
endmodule : ftfc_buf

// [core/ftfc_host.sv]
// Behaviour
// - widen only side by side, no depth
// - composite ready is AND of all flags
// - pulse master reset low before use
// - ready low one fall-through means full/empty
// - strobe rates stay within rated maximum
// - slower reads when outputs share bus
`timescale 1ns/1ps
`include "ftfc_defs.svh"
module ftfc_host
#(
   parameter int WIDTH    = `FTFC_WIDTH,
   parameter int LANES    = 1,
   parameter int BUF_DEP  = `FTFC_BUF_DEPTH,
   parameter bit SHARED_BUS = 1'b0
)
(
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   input  wire logic                   flush,
   input  wire logic [WIDTH*LANES-1:0] wr_data,
   input  wire logic                   wr_valid,
   output logic                        wr_ready,
   output logic      [WIDTH*LANES-1:0] rd_data,
   output logic                        rd_valid,
   input  wire logic                   rd_ready,
   output ftfc_pkg::ftfc_status_t      status,
   output ftfc_pkg::ftfc_strobe_t      strobe,
   output logic      [WIDTH*LANES-1:0] fifo_din,
   input  wire logic [LANES-1:0]       input_ready,
   input  wire logic [LANES-1:0]       output_ready,
   input  wire logic [WIDTH*LANES-1:0] fifo_dout
);
   localparam int W  = WIDTH * LANES;
   localparam int TW = 10;
   localparam logic [TW-1:0] TPT_CYC = TW'(`FTFC_TPT_CYC);
   localparam logic [TW-1:0] STB_CYC = TW'(`FTFC_STROBE_CYC);
   localparam logic [TW-1:0] BUS_CYC = TW'(`FTFC_BUS_CYC);
   localparam logic [TW-1:0] MRW_CYC = TW'(`FTFC_MRW_CYC);
   localparam logic [TW-1:0] MRS_CYC = TW'(`FTFC_MRS_CYC);
   localparam logic [TW-1:0] RD_CYC  = SHARED_BUS ? BUS_CYC : STB_CYC;

   if (WIDTH != 4 && WIDTH != 5)
   begin : g_bad_width
      $error("ftfc_host width must be 4 or 5");
   end
   if (LANES < 1)
   begin : g_bad_lanes
      $error("ftfc_host needs at least one lane");
   end

   // composite flags, since lanes fall through at different speeds
   logic ir_all;
   logic or_all;
   assign ir_all = &input_ready;
   assign or_all = &output_ready;

   // write side buffer so a stalled chip backs up into the source
   logic [W-1:0] bw_data;
   logic         bw_valid;
   logic         bw_take;

   ftfc_buf #(.WIDTH(W), .DEPTH(BUF_DEP)) u_wbuf
   (
      .core_clk  (core_clk),
      .reset     (reset),
      .in_data   (wr_data),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .out_data  (bw_data),
      .out_valid (bw_valid),
      .out_ready (bw_take)
   );

   // master reset sequencing
   ftfc_pkg::ftfc_wr_state_t wst_reg;
   logic [TW-1:0] wcnt_reg;
   logic          mr_n_reg;
   logic          si_reg;
   logic [W-1:0]  din_reg;
   logic          so_reg;
   logic          flush_take;

   // flush waits for shift-out low so no read pulse is cut short
   assign flush_take = (wst_reg == ftfc_pkg::FTFC_WR_IDLE) && flush && !so_reg;
   assign bw_take = (wst_reg == ftfc_pkg::FTFC_WR_IDLE) && bw_valid && ir_all && !flush;

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         wst_reg  <= ftfc_pkg::FTFC_WR_RESET;
         wcnt_reg <= '0;
         mr_n_reg <= 1'b0;
         si_reg   <= 1'b0;
         din_reg  <= '0;
      end
      else
      begin
         case (wst_reg)
            ftfc_pkg::FTFC_WR_RESET:
            begin
               // low pulse, then recovery before the first shift-in
               wcnt_reg <= wcnt_reg + 1'b1;
               if (wcnt_reg == MRW_CYC - 1'b1)
                  mr_n_reg <= 1'b1;
               if (wcnt_reg == MRW_CYC + MRS_CYC - 1'b1)
               begin
                  wst_reg  <= ftfc_pkg::FTFC_WR_IDLE;
                  wcnt_reg <= '0;
               end
            end
            ftfc_pkg::FTFC_WR_IDLE:
            begin
               if (flush_take)
               begin
                  wst_reg  <= ftfc_pkg::FTFC_WR_RESET;
                  mr_n_reg <= 1'b0;
                  wcnt_reg <= '0;
               end
               else if (bw_take)
               begin
                  din_reg  <= bw_data;
                  si_reg   <= 1'b1;
                  wst_reg  <= ftfc_pkg::FTFC_WR_HIGH;
                  wcnt_reg <= '0;
               end
            end
            ftfc_pkg::FTFC_WR_HIGH:
            begin
               wcnt_reg <= wcnt_reg + 1'b1;
               if (wcnt_reg == STB_CYC - 1'b1)
               begin
                  si_reg   <= 1'b0;
                  wst_reg  <= ftfc_pkg::FTFC_WR_LOW;
                  wcnt_reg <= '0;
               end
            end
            ftfc_pkg::FTFC_WR_LOW:
            begin
               wcnt_reg <= wcnt_reg + 1'b1;
               if (wcnt_reg == STB_CYC - 1'b1)
               begin
                  wst_reg  <= ftfc_pkg::FTFC_WR_IDLE;
                  wcnt_reg <= '0;
               end
            end
            default:
               wst_reg <= ftfc_pkg::FTFC_WR_RESET;
         endcase
      end
   end

   // read side: sample word on the edge that raises shift-out, word holds till it falls
   ftfc_pkg::ftfc_rd_state_t rst_reg;
   logic [TW-1:0] rcnt_reg;
   logic [W-1:0]  rdat_reg;
   logic          rval_reg;

   // cleared on the flush edge so shift-out is low while master reset is
   always_ff @(posedge core_clk)
   begin
      if (reset || !mr_n_reg || flush_take)
      begin
         rst_reg  <= ftfc_pkg::FTFC_RD_IDLE;
         rcnt_reg <= '0;
         so_reg   <= 1'b0;
         rdat_reg <= '0;
         rval_reg <= 1'b0;
      end
      else
      begin
         if (rval_reg && rd_ready)
            rval_reg <= 1'b0;
         case (rst_reg)
            ftfc_pkg::FTFC_RD_IDLE:
            begin
               if (or_all && (!rval_reg || rd_ready))
               begin
                  rdat_reg <= fifo_dout;
                  rval_reg <= 1'b1;
                  so_reg   <= 1'b1;
                  rst_reg  <= ftfc_pkg::FTFC_RD_HIGH;
                  rcnt_reg <= '0;
               end
            end
            ftfc_pkg::FTFC_RD_HIGH:
            begin
               rcnt_reg <= rcnt_reg + 1'b1;
               if (rcnt_reg == RD_CYC - 1'b1)
               begin
                  so_reg   <= 1'b0;
                  rst_reg  <= ftfc_pkg::FTFC_RD_LOW;
                  rcnt_reg <= '0;
               end
            end
            ftfc_pkg::FTFC_RD_LOW:
            begin
               rcnt_reg <= rcnt_reg + 1'b1;
               if (rcnt_reg == RD_CYC - 1'b1)
                  rst_reg <= ftfc_pkg::FTFC_RD_IDLE;
            end
            default:
               rst_reg <= ftfc_pkg::FTFC_RD_IDLE;
         endcase
      end
   end

   // full / empty once a flag stays low a fall-through time
   logic [TW-1:0] irlow_reg;
   logic [TW-1:0] orlow_reg;
   logic          full_reg;
   logic          empty_reg;

   always_ff @(posedge core_clk)
   begin
      if (reset || !mr_n_reg)
      begin
         irlow_reg <= '0;
         full_reg  <= 1'b0;
      end
      else if (ir_all || si_reg)
      begin
         irlow_reg <= '0;
         full_reg  <= 1'b0;
      end
      else if (irlow_reg != TPT_CYC)
         irlow_reg <= irlow_reg + 1'b1;
      else
         full_reg <= 1'b1;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset || !mr_n_reg)
      begin
         orlow_reg <= '0;
         empty_reg <= 1'b1;
      end
      else if (or_all || so_reg)
      begin
         orlow_reg <= '0;
         empty_reg <= 1'b0;
      end
      else if (orlow_reg != TPT_CYC)
         orlow_reg <= orlow_reg + 1'b1;
      else
         empty_reg <= 1'b1;
   end

   // single-lane strobes drive every chip together
   assign strobe.master_reset_n = mr_n_reg;
   assign strobe.shift_in       = si_reg;
   assign strobe.shift_out      = so_reg;
   assign fifo_din              = din_reg;
   assign rd_data               = rdat_reg;
   assign rd_valid              = rval_reg;
   assign status.full           = full_reg;
   assign status.empty          = empty_reg;
endmodule : ftfc_host

// [dv/fall_through_fifo_64x5_tb.sv]
`timescale 1ns/1ps
module fall_through_fifo_64x5_tb;
   localparam int W = 5;
   logic                   core_clk = 1'b0;
   logic                   reset    = 1'b1;
   logic                   flush    = 1'b0;
   logic [W-1:0]           wr_data  = '0;
   logic                   wr_valid = 1'b0;
   logic                   rd_ready = 1'b0;
   logic                   wr_ready;
   logic [W-1:0]           rd_data;
   logic                   rd_valid;
   ftfc_pkg::ftfc_status_t status;
   ftfc_pkg::ftfc_strobe_t strobe;
   logic [W-1:0]           fifo_din;
   logic                   input_ready;
   logic                   output_ready;
   logic [W-1:0]           fifo_dout;
   int                     err_count = 0;
   int                     checked   = 0;

   always #10 core_clk = ~core_clk;

   ftfc_host dut_u
   (
      .core_clk(core_clk), .reset(reset), .flush(flush),
      .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .status(status), .strobe(strobe), .fifo_din(fifo_din),
      .input_ready(input_ready), .output_ready(output_ready), .fifo_dout(fifo_dout)
   );

   ftfc_dev_model #(.W(W)) chip_u
   (
      .core_clk(core_clk), .master_reset_n(strobe.master_reset_n),
      .shift_in(strobe.shift_in), .shift_out(strobe.shift_out), .din(fifo_din),
      .input_ready(input_ready), .output_ready(output_ready), .dout(fifo_dout)
   );

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop

   task automatic push_words(input int n, input logic [W-1:0] base);
      int k;
      for (int i = 0; i < n; i++)
      begin
         wr_data  <= base + W'(i);
         wr_valid <= 1'b1;
         k = 0;
         do
         begin
            @(posedge core_clk);
            k++;
         end
         while (wr_ready !== 1'b1 && k < 2000);
      end
      wr_valid <= 1'b0;
   endtask : push_words

   task automatic pop_words(input int n, input logic [W-1:0] base);
      int k;
      rd_ready <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         k = 0;
         do
         begin
            @(posedge core_clk);
            k++;
         end
         while (rd_valid !== 1'b1 && k < 2000);
         check("rd_data", rd_data, W'(base + W'(i)));
      end
      rd_ready <= 1'b0;
   endtask : pop_words

   task automatic t_reset;
      check("master_reset_n", strobe.master_reset_n, 1'b0);
      check("empty", status.empty, 1'b1);
      reset <= 1'b0;
      repeat (10) @(posedge core_clk);
      check("master_reset_n", strobe.master_reset_n, 1'b1);
      repeat (40) @(posedge core_clk);
      check("empty", status.empty, 1'b1);
      $display("test reset done");
   endtask : t_reset

   task automatic t_order;
      push_words(20, 5'h03);
      pop_words(20, 5'h03);
      repeat (40) @(posedge core_clk);
      check("empty", status.empty, 1'b1);
      check("full", status.full, 1'b0);
      $display("test order done");
   endtask : t_order

   // 64 in the chip, 8 in the buffer, 1 in the read register
   task automatic t_full;
      push_words(73, 5'h10);
      repeat (45) @(posedge core_clk);
      check("full", status.full, 1'b1);
      check("input_ready", input_ready, 1'b0);
      check("wr_ready", wr_ready, 1'b0);
      pop_words(73, 5'h10);
      repeat (40) @(posedge core_clk);
      check("empty", status.empty, 1'b1);
      $display("test full done");
   endtask : t_full

   task automatic t_flush;
      logic seen;
      seen = 1'b0;
      push_words(5, 5'h00);
      repeat (50) @(posedge core_clk);
      flush <= 1'b1;
      @(posedge core_clk);
      flush <= 1'b0;
      for (int k = 0; k < 10; k++)
      begin
         @(posedge core_clk);
         if (strobe.master_reset_n === 1'b0)
            seen = 1'b1;
      end
      check("flush pulse", seen, 1'b1);
      repeat (50) @(posedge core_clk);
      check("rd_valid", rd_valid, 1'b0);
      check("empty", status.empty, 1'b1);
      push_words(3, 5'h14);
      pop_words(3, 5'h14);
      $display("test flush done");
   endtask : t_flush

   initial
   begin
      repeat (20) @(posedge core_clk);
      t_reset();
      t_order();
      t_full();
      t_flush();
      report_and_stop();
   end

   initial
   begin
      repeat (8000) @(posedge core_clk);
      err_count++;
      report_and_stop();
   end
endmodule : fall_through_fifo_64x5_tb

// [dv/ftfc_dev_model.sv]
`timescale 1ns/1ps
module ftfc_dev_model
#(
   parameter int W  = 5,
   parameter int D  = 64,
   parameter int FT = 10
)
(
   input wire logic         core_clk,
   input wire logic         master_reset_n,
   input wire logic         shift_in,
   input wire logic         shift_out,
   input wire logic [W-1:0] din,
   output logic             input_ready,
   output logic             output_ready,
   output logic     [W-1:0] dout
);
   logic [W-1:0] word_q[$];
   logic         taken_reg;
   int           wait_cnt;
   // strobes are levels sampled on the core clock
   always @(posedge core_clk)
   begin
      if (master_reset_n !== 1'b1)
      begin
         word_q.delete();
         input_ready  <= 1'b0;
         output_ready <= 1'b0;
         dout         <= '0;
         taken_reg    <= 1'b0;
         wait_cnt     <= 0;
      end
      else
      begin
         // a held shift-in never loads when space appears; ready only rises while shift-in is low
         if (shift_in && input_ready)
         begin
            word_q.push_back(din);
            input_ready <= 1'b0;
         end
         else if (!shift_in)
            input_ready <= (word_q.size() < D);
         if (output_ready && shift_out)
         begin
            output_ready <= 1'b0;
            taken_reg    <= 1'b1;
         end
         if (taken_reg && !shift_out)
         begin
            void'(word_q.pop_front());
            dout      <= ~dout;
            taken_reg <= 1'b0;
         end
         else if (!output_ready && !taken_reg && word_q.size() > 0)
         begin
            wait_cnt <= (wait_cnt == FT) ? 0 : wait_cnt + 1;
            if (wait_cnt == FT)
            begin
               output_ready <= 1'b1;
               dout         <= word_q[0];
            end
         end
      end
   end
endmodule : ftfc_dev_model

// [dv/ftfc_host_chk.sv]
`timescale 1ns/1ps
module ftfc_host_chk
#(
   parameter int WIDTH = 5,
   parameter int LANES = 1
)
(
   input wire logic                   core_clk,
   input wire logic                   reset,
   input wire logic                   flush,
   input wire logic [WIDTH*LANES-1:0] wr_data,
   input wire logic                   wr_valid,
   input wire logic                   wr_ready,
   input wire logic [WIDTH*LANES-1:0] rd_data,
   input wire logic                   rd_valid,
   input wire logic                   rd_ready,
   input wire ftfc_pkg::ftfc_status_t status,
   input wire ftfc_pkg::ftfc_strobe_t strobe,
   input wire logic [WIDTH*LANES-1:0] fifo_din,
   input wire logic [LANES-1:0]       input_ready,
   input wire logic [LANES-1:0]       output_ready,
   input wire logic [WIDTH*LANES-1:0] fifo_dout
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   logic [7:0] ir_low_reg;
   // saturates so a long full spell cannot wrap back to zero
   always_ff @(posedge core_clk)
   begin
      if (reset || (&input_ready))
         ir_low_reg <= 8'h00;
      else if (ir_low_reg != 8'hff)
         ir_low_reg <= ir_low_reg + 8'h01;
   end
   sequence si_pulse_s;
      strobe.shift_in [*2] ##1 !strobe.shift_in [*2];
   endsequence
   sequence so_pulse_s;
      strobe.shift_out [*2] ##1 !strobe.shift_out [*2];
   endsequence
   mr_width_a: assert property ($rose(strobe.master_reset_n) |->
      !$past(strobe.master_reset_n, 2)) else $error("master reset pulse too short");
   mr_setup_a: assert property ($rose(strobe.master_reset_n) |->
      !strobe.shift_in [*2]) else $error("shift-in too soon after master reset");
   mr_quiet_a: assert property (!strobe.master_reset_n |->
      !strobe.shift_in && !strobe.shift_out) else $error("strobe during master reset");
   si_gated_a: assert property ($rose(strobe.shift_in) |->
      &$past(input_ready)) else $error("shift-in without composite ready");
   si_shape_a: assert property ($rose(strobe.shift_in) |-> si_pulse_s)
      else $error("shift-in pulse shape wrong");
   so_gated_a: assert property ($rose(strobe.shift_out) |->
      &$past(output_ready)) else $error("shift-out without composite ready");
   so_shape_a: assert property ($rose(strobe.shift_out) |-> so_pulse_s)
      else $error("shift-out pulse shape wrong");
   full_flag_a: assert property ($rose(status.full) |-> ir_low_reg >= 8'h20)
      else $error("full flagged too early");
endmodule : ftfc_host_chk

bind ftfc_host ftfc_host_chk #(.WIDTH(WIDTH), .LANES(LANES)) chk_u
(
   .core_clk(core_clk), .reset(reset), .flush(flush),
   .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
   .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
   .status(status), .strobe(strobe), .fifo_din(fifo_din),
   .input_ready(input_ready), .output_ready(output_ready), .fifo_dout(fifo_dout)
);

// [shared/ftfc_defs.svh]
`ifndef FTFC_DEFS_SVH
`define FTFC_DEFS_SVH

`define FTFC_DEPTH          64
`define FTFC_WIDTH          5
`define FTFC_CLK_NS         20
`define FTFC_TPT_NS         650
`define FTFC_TPT_CYC        ((`FTFC_TPT_NS + `FTFC_CLK_NS - 1) / `FTFC_CLK_NS)
`define FTFC_STROBE_NS      29
`define FTFC_STROBE_CYC     ((`FTFC_STROBE_NS + `FTFC_CLK_NS - 1) / `FTFC_CLK_NS)
`define FTFC_BUS_NS         100
`define FTFC_BUS_CYC        ((`FTFC_BUS_NS + `FTFC_CLK_NS - 1) / `FTFC_CLK_NS)
`define FTFC_MRW_NS         30
`define FTFC_MRW_CYC        ((`FTFC_MRW_NS + `FTFC_CLK_NS - 1) / `FTFC_CLK_NS)
`define FTFC_MRS_NS         35
`define FTFC_MRS_CYC        ((`FTFC_MRS_NS + `FTFC_CLK_NS - 1) / `FTFC_CLK_NS)
`define FTFC_BUF_DEPTH      8

`endif

// [shared/ftfc_pkg.sv]
package ftfc_pkg;

   typedef enum logic [1:0]
   {
      FTFC_WR_RESET,
      FTFC_WR_IDLE,
      FTFC_WR_HIGH,
      FTFC_WR_LOW
   } ftfc_wr_state_t;

   typedef enum logic [1:0]
   {
      FTFC_RD_IDLE,
      FTFC_RD_HIGH,
      FTFC_RD_LOW
   } ftfc_rd_state_t;

   // strobe pins toward the buffer chips
   typedef struct packed
   {
      logic master_reset_n;
      logic shift_in;
      logic shift_out;
   } ftfc_strobe_t;

   // composite status as seen by the host
   typedef struct packed
   {
      logic full;
      logic empty;
   } ftfc_status_t;

endpackage : ftfc_pkg
